// File: common/asm_pkg.sv
// Package for the asynchronous SRAM host controller.
// Assumes a single 200 MHz clock; timing counts are derived here.
`default_nettype none
package asm_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int CLK_MHZ = 200;
    // Power-on wait before first access, microseconds
    localparam int POWER_US = 100;
    localparam int POWER_CYC = POWER_US * CLK_MHZ;
    // Access phases in cycles (5 ns each); covers slowest speed grade
    localparam int ACC_NS = 15;
    localparam int ACC_CYC = (ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 16;
    // Depth of the read data synchroniser, in cycles
    localparam int SYNC_CYC = 2;
    localparam logic [1:0] LANES_OFF = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0]        lane_n;
        logic              write;
    } asm_req_t;

    typedef struct packed {
        logic              chip_sel_n;
        logic              out_drive_n;
        logic              wr_strobe_n;
        logic              low_lane_enable_n;
        logic              high_lane_enable_n;
    } asm_ctl_t;

    typedef enum logic [2:0] {
        ASM_POWER, ASM_IDLE, ASM_RD, ASM_WR, ASM_WR_END
    } asm_state_t;
endpackage
`default_nettype wire

// File: hdl/asm_host.sv
// Host controller driving an asynchronous 64K x 16 SRAM through its pins.
// Assumes the memory sits on the board pins; data bus is split in/out/oe.
// Function
// R1: The memory holds 65,536 16-bit words in two separately usable lanes.
// R2: Select, output drive, write strobe and both lane enables are active low.
// R3: With select high the memory ignores other controls and floats its bus.
// R4: Select and output drive low with strobe high reads enabled lanes.
// R5: Select and strobe low write enabled lanes and the memory never drives.
// R6: Output drive and strobe both high, or both lanes off, means no access.
// R7: A write lasts while select, strobe and a lane enable are all low.
// R8: Write data setup and hold are timed to the signal that ends the write.
// R9: Select and strobe rising together leave the memory bus floating.
// R10: The host waits at least 100 us after power before the first access.
// R11: Address changes under a held read give new data without new strobes.
// R12: The host holds the write strobe high throughout every read.
// R13: The address is valid no later than select falls on a read.
// R14: Contents are kept across standby and disabled periods while powered.
`default_nettype none
module asm_host
    import asm_pkg::*;
#(
    parameter int POWER_WAIT = POWER_CYC
)(
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              NRST,
    // Request side
    input  wire logic              REQ_VALID,
    output logic                   REQ_READY,
    input  wire asm_req_t          REQ,
    output logic                   RSP_VALID,
    output logic [DATA_W-1:0]      RSP_DATA,
    // Memory pins
    output logic [ADDR_W-1:0]      MEM_ADDR,
    output asm_ctl_t               MEM_CTL,
    input  wire logic [DATA_W-1:0] MEM_DQ_IN,
    output logic [DATA_W-1:0]      MEM_DQ_OUT,
    output logic                   MEM_DQ_OE
);
    asm_state_t        state;
    logic [CNT_W-1:0]  cnt;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic              rd_op;
    logic              hit_end;

    assign hit_end = (cnt == CNT_W'(0));
    // Only accept after the power wait and when idle
    assign REQ_READY = (state == ASM_IDLE); // see R10

    // All lanes off is no access at all, so such requests are dropped
    function automatic logic req_live(input asm_req_t r);
        return r.lane_n != LANES_OFF; // see R6
    endfunction

    // Pin data passes two flops before use
    always_ff @(posedge CLK)
    begin
        dq_s1 <= MEM_DQ_IN;
        dq_s2 <= dq_s1;
    end

    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            state <= ASM_POWER;
            cnt   <= CNT_W'(POWER_WAIT - 1);
            rd_op <= 1'b0;
        end
        else
        begin
            unique case (state)
                ASM_POWER:
                    if (hit_end)
                        state <= ASM_IDLE; // see R10
                    else
                        cnt <= cnt - CNT_W'(1);
                ASM_IDLE:
                    if (REQ_VALID && req_live(REQ))
                    begin
                        rd_op <= !REQ.write;
                        // Extra two cycles let read data cross the synchroniser
                        cnt   <= REQ.write ? CNT_W'(ACC_CYC)
                                           : CNT_W'(ACC_CYC + SYNC_CYC);
                        state <= REQ.write ? ASM_WR : ASM_RD;
                    end
                ASM_RD:
                    // Idle turnaround: the memory needs time to float its
                    // outputs before the host may drive a following write
                    if (hit_end)
                        state <= ASM_WR_END; // see R5
                    else
                        cnt <= cnt - CNT_W'(1);
                ASM_WR:
                    if (hit_end)
                        state <= ASM_WR_END;
                    else
                        cnt <= cnt - CNT_W'(1);
                ASM_WR_END:
                    state <= ASM_IDLE;
                default:
                    state <= ASM_IDLE;
            endcase
        end
    end

    // Address and data latched at request; held through the strobe
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            MEM_ADDR   <= '0;
            MEM_DQ_OUT <= '0;
            MEM_CTL    <= '1; // see R3
            MEM_DQ_OE  <= 1'b0;
        end
        else
        begin
            unique case (state)
                ASM_IDLE:
                    if (REQ_READY && REQ_VALID && req_live(REQ))
                    begin
                        MEM_ADDR   <= REQ.addr; // see R13
                        MEM_DQ_OUT <= REQ.wdata;
                        MEM_CTL.chip_sel_n  <= 1'b0;
                        MEM_CTL.out_drive_n <= REQ.write; // see R4
                        MEM_CTL.wr_strobe_n <= !REQ.write; // see R12
                        MEM_CTL.low_lane_enable_n  <= REQ.lane_n[0]; // see R2
                        MEM_CTL.high_lane_enable_n <= REQ.lane_n[1];
                        MEM_DQ_OE  <= REQ.write; // see R5
                    end
                ASM_RD:
                    if (hit_end)
                        MEM_CTL <= '1;
                ASM_WR:
                    // Strobe and select rise together; data held one cycle after end
                    if (hit_end)
                        MEM_CTL <= '1; // see R7 R8 R9
                ASM_WR_END:
                    MEM_DQ_OE <= 1'b0; // see R8
                default:
                    MEM_CTL <= '1;
            endcase
        end
    end

    // Read data captured on the last cycle of the read window
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            RSP_VALID <= 1'b0;
            RSP_DATA  <= '0;
        end
        else
        begin
            RSP_VALID <= (state == ASM_RD) && hit_end && rd_op; // see R4
            if ((state == ASM_RD) && hit_end)
                RSP_DATA <= dq_s2;
        end
    end

    AST_STROBE_HIGH_ON_READ: // see R12
        assert property (@(posedge CLK) disable iff (!NRST)
            (state == ASM_RD) |-> MEM_CTL.wr_strobe_n)
        else $error("write strobe low during read");
    AST_NO_DRIVE_ON_READ: // see R4
        assert property (@(posedge CLK) disable iff (!NRST)
            !MEM_CTL.out_drive_n |-> !MEM_DQ_OE)
        else $error("host drives bus while memory output enabled");
    AST_DATA_HOLD: // see R8
        assert property (@(posedge CLK) disable iff (!NRST)
            $rose(MEM_CTL.wr_strobe_n) |-> MEM_DQ_OE && $stable(MEM_DQ_OUT))
        else $error("write data not held at write end");
    AST_ADDR_STABLE: // see R13
        assert property (@(posedge CLK) disable iff (!NRST)
            !MEM_CTL.chip_sel_n && !$rose(!MEM_CTL.chip_sel_n)
            |-> $stable(MEM_ADDR))
        else $error("address moved while selected");
    AST_POWER_WAIT: // see R10
        assert property (@(posedge CLK) disable iff (!NRST)
            (state == ASM_POWER) |-> MEM_CTL.chip_sel_n)
        else $error("access during power wait");
    AST_WRITE_LEN: // see R7
        assert property (@(posedge CLK) disable iff (!NRST)
            $fell(MEM_CTL.wr_strobe_n) |-> !MEM_CTL.wr_strobe_n [*3])
        else $error("write pulse too short");
    AST_READ_RESP: // see R4
        assert property (@(posedge CLK) disable iff (!NRST)
            $fell(MEM_CTL.out_drive_n) |-> ##[5:6] RSP_VALID)
        else $error("read response late");
    AST_LANES_ON: // see R6
        assert property (@(posedge CLK) disable iff (!NRST)
            !MEM_CTL.chip_sel_n |->
            !(MEM_CTL.low_lane_enable_n && MEM_CTL.high_lane_enable_n))
        else $error("select with no lane enabled");
    // Write ends by strobe and select rising on one edge
    AST_END_TOGETHER: // see R9
        assert property (@(posedge CLK) disable iff (!NRST)
            $rose(MEM_CTL.wr_strobe_n) |-> $rose(MEM_CTL.chip_sel_n))
        else $error("strobe and select did not rise together");
    AST_WRITE_ADDR_HOLD: // see R8
        assert property (@(posedge CLK) disable iff (!NRST)
            $rose(MEM_CTL.wr_strobe_n) |-> $stable(MEM_ADDR))
        else $error("address moved at write end");
    // Catches a write launched before read data has floated
    AST_TURNAROUND: // see R5
        assert property (@(posedge CLK) disable iff (!NRST)
            $rose(MEM_DQ_OE) |-> $past(MEM_CTL.out_drive_n, 2))
        else $error("host drove bus right after a read");
    AST_LANES_STEADY: // see R8
        assert property (@(posedge CLK) disable iff (!NRST)
            !MEM_CTL.chip_sel_n && !$past(MEM_CTL.chip_sel_n)
            |-> $stable({MEM_CTL.low_lane_enable_n,
                         MEM_CTL.high_lane_enable_n}))
        else $error("lane enables moved while selected");
    AST_STROBE_ONLY_WRITE: // see R12
        assert property (@(posedge CLK) disable iff (!NRST)
            !MEM_CTL.wr_strobe_n |-> MEM_DQ_OE && MEM_CTL.out_drive_n)
        else $error("write strobe low without write drive");
endmodule // asm_host
`default_nettype wire

// File: dv/asm_sram_model.sv
// Behavioural model of the 64K x 16 async SRAM on the host's pins.
// Assumes the bench resolves the shared data bus and feeds it back.
`default_nettype none
module asm_sram_model
    import asm_pkg::*;
#(
    parameter int DLY_NS = 8
)(
    // Host pins
    input  wire logic [ADDR_W-1:0] addr,
    input  wire asm_ctl_t          ctl,
    input  wire logic [DATA_W-1:0] dq,
    // Device drive
    output logic [DATA_W-1:0]      dq_drv,
    output logic [1:0]             dq_en
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DATA_W-1:0] mem [0:65535];
    logic [DATA_W-1:0] last;
    logic [1:0]        lane_on;
    logic              wr;
    logic              rd;
    initial last = 16'hA55A;
    assign lane_on = ~{ctl.high_lane_enable_n, ctl.low_lane_enable_n};
    assign wr = !ctl.chip_sel_n && !ctl.wr_strobe_n && |lane_on;
    assign rd = !ctl.chip_sel_n && !ctl.out_drive_n && ctl.wr_strobe_n;
    // Delayed release keeps read data alive past the select and output drive edge
    assign #(DLY_NS) dq_en = rd ? lane_on : 2'h0;
    // Level write: data must hold while the overlap lasts
    always @*
        if (wr)
        begin
            if (lane_on[0])
                mem[addr][7:0] = dq[7:0];
            if (lane_on[1])
                mem[addr][15:8] = dq[15:8];
        end
    for (genvar i = 0; i < 2; i++)
    begin : g_lane
        always @*
            if (dq_en[i])
                last[i*8+:8] = mem[addr][i*8+:8];
        // Released lane shows inverse, never stale data
        assign dq_drv[i*8+:8] = dq_en[i] ? mem[addr][i*8+:8] : ~last[i*8+:8];
    end
endmodule // asm_sram_model
`default_nettype wire

// File: dv/async_sram_byte_lane_access_test.sv
// Self-checking bench for the async SRAM host controller.
// Assumes asm_host and the SRAM model; power wait shortened.
`default_nettype none
module async_sram_byte_lane_access_test;
    timeunit 1ns;
    timeprecision 100ps;
    import asm_pkg::*;
    localparam int PW = 10;
    logic CLK = 0, NRST = 0, REQ_VALID = 0, REQ_READY, RSP_VALID, MEM_DQ_OE;
    asm_req_t REQ = '0;
    asm_ctl_t MEM_CTL;
    logic [15:0] RSP_DATA, MEM_DQ_OUT, MEM_ADDR, bus, mdl_dq, rdat;
    logic [1:0] mdl_en;
    int err_count = 0, comparisons = 0;
    always #2.5 CLK = ~CLK;
    assign bus = MEM_DQ_OE ? MEM_DQ_OUT : mdl_dq;
    asm_host #(.POWER_WAIT(PW)) uut (.CLK(CLK), .NRST(NRST),
        .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ),
        .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .MEM_ADDR(MEM_ADDR),
        .MEM_CTL(MEM_CTL), .MEM_DQ_IN(bus), .MEM_DQ_OUT(MEM_DQ_OUT),
        .MEM_DQ_OE(MEM_DQ_OE));
    asm_sram_model mdl (.addr(MEM_ADDR), .ctl(MEM_CTL), .dq(bus),
        .dq_drv(mdl_dq), .dq_en(mdl_en));
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_for(bit rsp);
        for (int i = 0; i < 100 && (rsp ? RSP_VALID : REQ_READY) !== 1; i++)
            @(negedge CLK);
        if ((rsp ? RSP_VALID : REQ_READY) !== 1)
        begin
            err_count++;
            $display("ERROR handshake expected 1 seen 0");
            test_done();
        end
    endtask
    task automatic access(bit wr, logic [15:0] a, d, logic [1:0] ln);
        wait_for(0);
        REQ = '{addr: a, wdata: d, lane_n: ln, write: wr};
        REQ_VALID = 1;
        @(negedge CLK);
        REQ_VALID = 0;
        if (!wr)
        begin
            wait_for(1);
            rdat = RSP_DATA;
        end
    endtask
    // Contention and read-as-write hazards on the pins
    always @(negedge CLK)
        if (NRST && (MEM_DQ_OE && |mdl_en || !MEM_CTL.out_drive_n
            && !MEM_CTL.wr_strobe_n))
        begin
            err_count++;
            $display("ERROR bus expected quiet seen %b", mdl_en);
        end
    task automatic t_power();
        int n;
        chk("idle ctl", 16'h001F, {11'h0, MEM_CTL});
        chk("oe ready", 16'h0, {14'h0, MEM_DQ_OE, REQ_READY});
        NRST = 1;
        for (n = 0; n < 100 && REQ_READY !== 1; n++)
            @(negedge CLK);
        chk("power wait", 16'(PW), n[15:0]);
        $display("test power done");
    endtask
    task automatic t_word();
        access(1, 16'hFFFF, 16'hC3A5, 2'h0);
        access(1, 16'h0000, 16'h1234, 2'h0);
        access(0, 16'hFFFF, 16'h0, 2'h0);
        chk("word top", 16'hC3A5, rdat);
        access(0, 16'h0000, 16'h0, 2'h0);
        chk("word zero", 16'h1234, rdat);
        $display("test word done");
    endtask
    task automatic t_lanes();
        access(1, 16'hFFFF, 16'h00EE, 2'h2);
        access(1, 16'hFFFF, 16'h7700, 2'h1);
        access(0, 16'hFFFF, 16'h0, 2'h0);
        chk("lane merge", 16'h77EE, rdat);
        access(0, 16'hFFFF, 16'h0, 2'h2);
        chk("low lane", 16'h00EE, {8'h0, rdat[7:0]});
        $display("test lanes done");
    endtask
    task automatic t_none();
        access(1, 16'h0000, 16'hFFFF, 2'h3);
        repeat (3) @(negedge CLK);
        chk("no access", 16'h003F, {10'h0, MEM_CTL, REQ_READY});
        access(0, 16'h0000, 16'h0, 2'h0);
        chk("kept", 16'h1234, rdat);
        $display("test none done");
    endtask
    initial
    begin
        repeat (5) @(negedge CLK);
        t_power();
        t_word();
        t_lanes();
        t_none();
        test_done();
    end
endmodule // async_sram_byte_lane_access_test
`default_nettype wire
